// ===== common/nvac_pkg.sv
/*
  Package for the nonvolatile access control block: register indices,
  control bit positions, reset values, unlock keys and timing counts.
  Assumes a 100 MHz system clock.
*/
package nvac_pkg;
  localparam logic [3:0] ADDR_TBL_UPPER   = 4'h0;
  localparam logic [3:0] ADDR_TBL_HIGH    = 4'h1;
  localparam logic [3:0] ADDR_TBL_LOW     = 4'h2;
  localparam logic [3:0] ADDR_TBL_LATCH   = 4'h3;
  localparam logic [3:0] ADDR_UNLOCK_KEY  = 4'h4;
  localparam logic [3:0] ADDR_NVM_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_NVM_DATA    = 4'h6;
  localparam logic [3:0] ADDR_NVM_ADDR_LO = 4'h7;
  localparam logic [3:0] ADDR_NVM_ADDR_HI = 4'h8;
  localparam logic [3:0] ADDR_PERIPH_FLAG = 4'h9;
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'hA;

  localparam int BIT_PROG_SEL   = 7;
  localparam int BIT_CFG_SEL    = 6;
  localparam int BIT_ROW_ERASE  = 4;
  localparam int BIT_ABORT      = 3;
  localparam int BIT_WR_ALLOW   = 2;
  localparam int BIT_WR_START   = 1;
  localparam int BIT_RD_START   = 0;
  localparam int BIT_DONE_FLAG  = 4;

  localparam logic [7:0] KEY_FIRST    = 8'h55;
  localparam logic [7:0] KEY_SECOND   = 8'hAA;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  localparam int DATA_DEPTH   = 1024;
  localparam int WRITE_TIME_US = 50;
  localparam int CLK_MHZ       = 100;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES  = WRITE_CYCLES / 2;
endpackage

// ===== design/nvac_data_array.sv
/*
  Flip-flop data byte array, 1024 locations, one write port and a
  combinational read port. Assumes the caller holds address and data
  steady while the write enable is high.
*/
`timescale 1ns/1ns
module nvac_data_array (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [9:0] addr,
  input  wire logic       eraseEn,
  input  wire logic       writeEn,
  input  wire logic [7:0] writeData,
  output logic      [7:0] readData
);
  logic [7:0] cells [nvac_pkg::DATA_DEPTH];

  // Erase drives the cell blank first, program stores the byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < nvac_pkg::DATA_DEPTH; i++) begin
        cells[i] <= 8'hFF;
      end
    end else if (eraseEn) begin
      cells[addr] <= 8'hFF;
    end else if (writeEn) begin
      cells[addr] <= writeData;
    end
  end

  // Read path is combinational from the held cells
  assign readData = cells[addr];
endmodule

// ===== design/nvac_top.sv
/*
  Nonvolatile access control: control register, unlock key port,
  address pair, data byte, table pointer and latch, self-timed writes.
  Assumes a one-cycle write/read strobe master and synchronous reset
  cause inputs from the system reset logic.
*/
`timescale 1ns/1ns
module nvac_top #(
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       softResetPulse,
  input  wire logic [3:0] busAddr,
  input  wire logic [7:0] busWriteData,
  input  wire logic       busWrite,
  input  wire logic       busRead,
  output logic      [7:0] busReadData,
  output logic            writeBusy,
  output logic            flashEraseStrobe,
  output logic            flashWriteStrobe,
  output logic            cfgWriteStrobe
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG  = 3'b100
  } nvac_state_type;

  typedef enum logic [2:0] {
    KEY_NONE = 3'b001,
    KEY_ONE  = 3'b010,
    KEY_TWO  = 3'b100
  } nvac_key_type;

  nvac_state_type state;
  nvac_key_type   keyState;
  logic [7:0]  tblUpper;
  logic [7:0]  tblHigh;
  logic [7:0]  tblLow;
  logic [7:0]  tblLatch;
  logic        progSel;
  logic        cfgSel;
  logic        rowErase;
  logic        abortFlag;
  logic        writeAllow;
  logic        writeStart;
  logic        readStart;
  logic        doneFlag;
  logic [7:0]  addrLow;
  logic [1:0]  addrHigh;
  logic [7:0]  dataByte;
  logic [31:0] timer;
  logic        arrayErase;
  logic        arrayWrite;
  logic [7:0]  arrayRead;
  logic        ctrlWrite;
  logic        startReq;
  logic        timerDone;
  logic        cutShort;
  logic [7:0]  next_readData;

  // Bus write to a given register index
  function automatic logic hit(input logic [3:0] a);
    return busWrite && (busAddr == a);
  endfunction

  assign ctrlWrite = hit(nvac_pkg::ADDR_NVM_CONTROL) && !writeStart;
  assign startReq  = ctrlWrite && busWriteData[nvac_pkg::BIT_WR_START]
                     && writeAllow && keyState == KEY_TWO;
  assign timerDone = (timer == 32'h0000_0001);
  // Reset event seen while a write runs
  assign cutShort  = softResetPulse && writeStart;

  nvac_data_array uArray (
    .clk       (clk),
    .rst_b     (rst_b),
    .addr      ({addrHigh, addrLow}),
    .eraseEn   (arrayErase),
    .writeEn   (arrayWrite),
    .writeData (dataByte),
    .readData  (arrayRead)
  );

  // Unlock key tracker, any other access breaks the sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      keyState <= KEY_NONE;
    end else if (hit(nvac_pkg::ADDR_UNLOCK_KEY)) begin
      if (busWriteData == nvac_pkg::KEY_FIRST) begin
        keyState <= KEY_ONE;
      end else if (busWriteData == nvac_pkg::KEY_SECOND && keyState == KEY_ONE) begin
        keyState <= KEY_TWO;
      end else begin
        keyState <= KEY_NONE;
      end
    end else if (busWrite || busRead) begin
      keyState <= KEY_NONE;
    end
  end

  // Control register bits owned by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      progSel    <= 1'b0;
      cfgSel     <= 1'b0;
      writeAllow <= 1'b0;  // clear at power-up
    end else if (ctrlWrite) begin
      progSel    <= busWriteData[nvac_pkg::BIT_PROG_SEL];
      cfgSel     <= busWriteData[nvac_pkg::BIT_CFG_SEL];
      writeAllow <= busWriteData[nvac_pkg::BIT_WR_ALLOW];
    end
  end

  // Row erase enable, cleared when a flash row erase completes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rowErase <= 1'b0;
    end else if (ctrlWrite) begin
      rowErase <= busWriteData[nvac_pkg::BIT_ROW_ERASE];
    end else if (state == ST_ERASE && timerDone && progSel && !cfgSel) begin
      rowErase <= 1'b0;
    end
  end

  // Write start and self-timed sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      writeStart <= 1'b0;
      timer      <= 32'h0000_0000;
    end else if (cutShort) begin
      state      <= ST_IDLE;
      writeStart <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (startReq) begin
            writeStart <= 1'b1;
            state      <= ST_ERASE;
            timer      <= WRITE_CYCLES;
          end
        end
        ST_ERASE: begin
          if (timerDone) begin
            if (progSel && !cfgSel && rowErase) begin
              state      <= ST_IDLE;
              writeStart <= 1'b0;
            end else begin
              state <= ST_PROG;
              timer <= WRITE_CYCLES;
            end
          end else begin
            timer <= timer - 32'h0000_0001;
          end
        end
        ST_PROG: begin
          if (timerDone) begin
            state      <= ST_IDLE;
            writeStart <= 1'b0;  // hardware clears
          end else begin
            timer <= timer - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Abort flag: set on a start attempt outside a running write or soft reset mid-write, clear on success
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abortFlag <= 1'b0;
    end else if (softResetPulse && writeStart) begin
      abortFlag <= 1'b1;
    end else if (startReq) begin
      abortFlag <= 1'b1;
    end else if (ctrlWrite && busWriteData[nvac_pkg::BIT_WR_START]) begin
      abortFlag <= 1'b1;
    end else if (state == ST_PROG && timerDone) begin
      abortFlag <= 1'b0;
    end else if (state == ST_ERASE && timerDone && progSel && !cfgSel && rowErase) begin
      abortFlag <= 1'b0;
    end
  end

  // Write-done flag: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      doneFlag <= 1'b0;
    end else if (writeStart && timerDone && !cutShort && (state == ST_PROG
                 || (progSel && !cfgSel && rowErase))) begin
      doneFlag <= 1'b1;  // completion sets flag
    end else if (hit(nvac_pkg::ADDR_PERIPH_FLAG)) begin
      doneFlag <= busWriteData[nvac_pkg::BIT_DONE_FLAG];
    end
  end

  // Read start: set by software, gone after one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readStart <= 1'b0;
    end else begin
      readStart <= ctrlWrite && busWriteData[nvac_pkg::BIT_RD_START]
                   && !busWriteData[nvac_pkg::BIT_PROG_SEL]
                   && !busWriteData[nvac_pkg::BIT_CFG_SEL];
    end
  end

  // Address pair, data byte and table registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrLow  <= nvac_pkg::RESET_BYTE;
      addrHigh <= 2'h0;
      dataByte <= nvac_pkg::RESET_BYTE;
      tblUpper <= nvac_pkg::RESET_BYTE;
      tblHigh  <= nvac_pkg::RESET_BYTE;
      tblLow   <= nvac_pkg::RESET_BYTE;
      tblLatch <= nvac_pkg::RESET_BYTE;
    end else begin
      if (!writeStart) begin
        if (hit(nvac_pkg::ADDR_NVM_ADDR_LO)) addrLow  <= busWriteData;
        if (hit(nvac_pkg::ADDR_NVM_ADDR_HI)) addrHigh <= busWriteData[1:0];
        if (hit(nvac_pkg::ADDR_NVM_DATA))    dataByte <= busWriteData;
        if (readStart) dataByte <= arrayRead;
      end
      if (hit(nvac_pkg::ADDR_TBL_UPPER)) tblUpper <= {2'b00, busWriteData[5:0]};
      if (hit(nvac_pkg::ADDR_TBL_HIGH))  tblHigh  <= busWriteData;
      if (hit(nvac_pkg::ADDR_TBL_LOW))   tblLow   <= busWriteData;
      if (hit(nvac_pkg::ADDR_TBL_LATCH)) tblLatch <= busWriteData;
    end
  end

  // Target strobes, routed by the select bits
  // data array routing, both select bits clear
  assign arrayErase = (state == ST_ERASE) && timerDone && !progSel && !cfgSel;
  assign arrayWrite = (state == ST_PROG) && timerDone && !progSel && !cfgSel;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flashEraseStrobe <= 1'b0;
      flashWriteStrobe <= 1'b0;
      cfgWriteStrobe   <= 1'b0;
      writeBusy        <= 1'b0;
    end else begin
      flashEraseStrobe <= (state == ST_ERASE) && timerDone && progSel && !cfgSel && rowErase;
      flashWriteStrobe <= (state == ST_PROG) && timerDone && progSel && !cfgSel;
      cfgWriteStrobe   <= (state == ST_PROG) && timerDone && cfgSel;
      writeBusy        <= (state != ST_IDLE) || startReq;
    end
  end

  // Read mux, answered one cycle after the strobe
  always_comb begin
    next_readData = 8'h00;
    unique case (busAddr)
      nvac_pkg::ADDR_TBL_UPPER:   next_readData = tblUpper;
      nvac_pkg::ADDR_TBL_HIGH:    next_readData = tblHigh;
      nvac_pkg::ADDR_TBL_LOW:     next_readData = tblLow;
      nvac_pkg::ADDR_TBL_LATCH:   next_readData = tblLatch;
      nvac_pkg::ADDR_UNLOCK_KEY:  next_readData = 8'h00;  // no storage
      nvac_pkg::ADDR_NVM_CONTROL: next_readData = {progSel, cfgSel, 1'b0, rowErase,
                                                   abortFlag, writeAllow, writeStart,
                                                   readStart};
      nvac_pkg::ADDR_NVM_DATA:    next_readData = dataByte;
      nvac_pkg::ADDR_NVM_ADDR_LO: next_readData = addrLow;
      nvac_pkg::ADDR_NVM_ADDR_HI: next_readData = {6'b00_0000, addrHigh};
      nvac_pkg::ADDR_PERIPH_FLAG: next_readData = {3'b000, doneFlag, 4'h0};
      default:                    next_readData = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busReadData <= 8'h00;
    end else begin
      busReadData <= busRead ? next_readData : 8'h00;
    end
  end

  AST_ABORT_AT_START: assert property (@(posedge clk) disable iff (!rst_b)
    startReq |=> abortFlag && writeStart) else $error("abort flag not set at start");
  AST_START_NEEDS_ALLOW: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(writeStart) |-> $past(writeAllow)) else $error("start without allow");
  AST_KEY_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(writeStart) |-> $past(keyState) == KEY_TWO) else $error("start without keys");
  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
    readStart && !(ctrlWrite && busWriteData[nvac_pkg::BIT_RD_START]) |=> !readStart)
    else $error("read start held");
  AST_READ_REFUSED: assert property (@(posedge clk) disable iff (!rst_b)
    readStart |-> !progSel && !cfgSel) else $error("read with flash select");
  AST_LOCKED: assert property (@(posedge clk) disable iff (!rst_b)
    writeStart && $past(writeStart) |-> $stable(addrLow) && $stable(progSel))
    else $error("registers changed mid write");
  AST_DONE_SETS: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(writeStart) && !$past(softResetPulse) |-> doneFlag && !abortFlag)
    else $error("done flag missing");
  AST_CUT_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
    softResetPulse && writeStart |=> abortFlag && !writeStart)
    else $error("cut write not flagged");
  AST_ERASE_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
    flashEraseStrobe |-> !rowErase && !writeStart)
    else $error("row erase bit kept");
  AST_KEY_READS_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    busRead && busAddr == nvac_pkg::ADDR_UNLOCK_KEY |=> busReadData == 8'h00)
    else $error("key port read nonzero");
endmodule

// ===== verif/tb_top.sv
/*
  Self-checking bench for the nonvolatile access control block.
  Drives the register port directly and checks the strobe outputs.
  Expected read data go into a queue that a negedge monitor drains.
  Assumes the block is built with a short write time.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
  localparam int WCYC = 4;
  logic        clk;
  logic        rst_b;
  logic        softResetPulse;
  logic  [3:0] busAddr;
  logic  [7:0] busWriteData;
  logic        busWrite;
  logic        busRead;
  logic  [7:0] busReadData;
  logic        writeBusy;
  logic        flashEraseStrobe;
  logic        flashWriteStrobe;
  logic        cfgWriteStrobe;
  logic [15:0] expQ[$];
  logic [15:0] note;
  logic        rdSeen;
  int          errors;
  int          checks;
  int          eraseCnt;
  int          progCnt;
  int          cfgCnt;
  logic  [7:0] lo;
  logic  [7:0] dat;
  logic  [7:0] ctl [3];
  int          expE [3];
  int          expP [3];
  int          expC [3];

  nvac_top #(.WRITE_CYCLES(WCYC)) nvac_top_i (
    .clk              (clk),
    .rst_b            (rst_b),
    .softResetPulse   (softResetPulse),
    .busAddr          (busAddr),
    .busWriteData     (busWriteData),
    .busWrite         (busWrite),
    .busRead          (busRead),
    .busReadData      (busReadData),
    .writeBusy        (writeBusy),
    .flashEraseStrobe (flashEraseStrobe),
    .flashWriteStrobe (flashWriteStrobe),
    .cfgWriteStrobe   (cfgWriteStrobe)
  );

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read answer monitor: data stand one cycle after the read strobe
  always @(negedge clk) begin
    if (rdSeen) begin
      note = expQ.pop_front();
      `CHK(busReadData & note[15:8], note[7:0]) // read answer
    end
    rdSeen = (busRead === 1'b1);
    if (flashEraseStrobe === 1'b1) eraseCnt++;
    if (flashWriteStrobe === 1'b1) progCnt++;
    if (cfgWriteStrobe === 1'b1) cfgCnt++;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    busAddr      <= a;
    busWriteData <= d;
    busWrite     <= 1'b1;
    busRead      <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    busAddr  <= a;
    busRead  <= 1'b1;
    busWrite <= 1'b0;
    expQ.push_back({m, e});
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      busWrite <= 1'b0;
      busRead  <= 1'b0;
    end
  endtask

  // Unlock keys followed directly by the control write
  task automatic keys(input logic [7:0] c);
    wr(nvac_pkg::ADDR_UNLOCK_KEY, nvac_pkg::KEY_FIRST);
    wr(nvac_pkg::ADDR_UNLOCK_KEY, nvac_pkg::KEY_SECOND);
    wr(nvac_pkg::ADDR_NVM_CONTROL, c);
  endtask

  task automatic waitDone();
    int k;
    k = 0;
    idle(1);
    @(negedge clk);
    while (writeBusy !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    `CHK(writeBusy, 1'b0) // bounded write time
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    softResetPulse = 1'b0;
    busAddr = 4'h0;
    busWriteData = 8'h00;
    busWrite = 1'b0;
    busRead = 1'b0;
    rdSeen = 1'b0;
    errors = 0;
    checks = 0;
    eraseCnt = 0;
    progCnt = 0;
    cfgCnt = 0;
    void'($urandom(49116));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Reset state, key port and plain registers
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h00, 8'hFF); // allow clear
    wr(nvac_pkg::ADDR_UNLOCK_KEY, 8'h5A);
    rd(nvac_pkg::ADDR_UNLOCK_KEY, 8'h00, 8'hFF); // reads zero
    rd(4'hB, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      dat = 8'($urandom);
      wr(4'(i), dat);
      rd(4'(i), dat & ((i == 0) ? 8'h3F : 8'hFF), (i == 0) ? 8'h3F : 8'hFF);
    end
    // Start without write allow is refused and flagged
    keys(8'h02);
    idle(1);
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h08, 8'hFF); // refused start
    // Proper data write at a high address
    lo = 8'($urandom);
    dat = 8'($urandom);
    wr(nvac_pkg::ADDR_NVM_ADDR_LO, lo);
    wr(nvac_pkg::ADDR_NVM_ADDR_HI, 8'h02);
    rd(nvac_pkg::ADDR_NVM_ADDR_HI, 8'h02, 8'h03); // two high bits
    wr(nvac_pkg::ADDR_NVM_DATA, dat);
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h04);
    keys(8'h06);
    idle(1);
    @(negedge clk);
    `CHK(writeBusy, 1'b1) // write started
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h0E, 8'hFF); // abort set at start
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h00);
    wr(nvac_pkg::ADDR_NVM_DATA, ~dat);
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h0E, 8'hFF); // start not cleared
    waitDone();
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h04, 8'hFF); // start and abort read zero after write
    rd(nvac_pkg::ADDR_PERIPH_FLAG, 8'h10, 8'h10); // done flag set
    wr(nvac_pkg::ADDR_PERIPH_FLAG, 8'h00);
    rd(nvac_pkg::ADDR_PERIPH_FLAG, 8'h00, 8'h10); // software clear
    // Read back, then an unwritten location differing in high bits only
    wr(nvac_pkg::ADDR_NVM_DATA, 8'h00);
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h05);
    idle(1);
    rd(nvac_pkg::ADDR_NVM_DATA, dat, 8'hFF); // stored byte
    wr(nvac_pkg::ADDR_NVM_ADDR_HI, 8'h00);
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h05);
    idle(1);
    rd(nvac_pkg::ADDR_NVM_DATA, 8'hFF, 8'hFF); // separate location
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h04, 8'hFF); // read start cleared
    // Read start ignored with a select bit set
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h81);
    idle(1);
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h80, 8'hC1); // program select
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h41);
    idle(1);
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h40, 8'hC1); // config select
    // Broken key sequence is refused
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h04);
    wr(nvac_pkg::ADDR_UNLOCK_KEY, nvac_pkg::KEY_FIRST);
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h04, 8'hFF);
    wr(nvac_pkg::ADDR_UNLOCK_KEY, nvac_pkg::KEY_SECOND);
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h06);
    idle(1);
    @(negedge clk);
    `CHK(writeBusy, 1'b0) // no start
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h0C, 8'hFF); // improper attempt
    // Target selection: flash write, config write, row erase
    ctl = '{8'h84, 8'hC4, 8'h94};
    expE = '{0, 0, 1};
    expP = '{1, 0, 0};
    expC = '{0, 1, 0};
    for (int i = 0; i < 3; i++) begin
      eraseCnt = 0;
      progCnt = 0;
      cfgCnt = 0;
      wr(nvac_pkg::ADDR_TBL_LOW, 8'($urandom));
      wr(nvac_pkg::ADDR_NVM_CONTROL, ctl[i]);
      keys(ctl[i] | 8'h02);
      waitDone();
      idle(2);
      `CHK(eraseCnt, expE[i]) // erase strobe
      `CHK(progCnt, expP[i]) // flash target
      `CHK(cfgCnt, expC[i]) // config target
      rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h00, 8'h1A); // erase bit cleared
    end
    // Reset event in mid-write flags abort and keeps selects
    progCnt = 0;
    wr(nvac_pkg::ADDR_NVM_CONTROL, 8'h84);
    keys(8'h86);
    idle(1);
    softResetPulse <= 1'b1;
    idle(1);
    softResetPulse <= 1'b0;
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h88, 8'hC8); // abort on reset
    waitDone();
    rd(nvac_pkg::ADDR_NVM_CONTROL, 8'h88, 8'hCA); // selects kept
    `CHK(progCnt, 0) // write cut short
    idle(3);
    report_and_stop();
  end
endmodule
